// ### hw/ttmc_map.svh
// constants of the tape transport mode controller
// assumes a 200 MHz pclk and the register layout below
`ifndef TTMC_MAP_SVH
`define TTMC_MAP_SVH
`define TTMC_ADDR_CTRL 12'h000
`define TTMC_ADDR_STAT 12'h004
`define TTMC_ADDR_IRQ_STAT 12'h008
`define TTMC_ADDR_IRQ_MASK 12'h00C
`define TTMC_ADDR_SETUP 12'h010
`define TTMC_CLK_NS 5
`define TTMC_LOCK_MS 2500
`define TTMC_LOCK_CYC (`TTMC_LOCK_MS * 1000000 / `TTMC_CLK_NS)
`define TTMC_DEB_NS 10000
`define TTMC_DEB_CYC (`TTMC_DEB_NS / `TTMC_CLK_NS)
`define TTMC_PAIR_NS 50000
`define TTMC_PAIR_CYC (`TTMC_PAIR_NS / `TTMC_CLK_NS)
`define TTMC_SETUP_RST 4'h6
`define TTMC_CTRL_MASTER_BIT 0
`define TTMC_NCH 4
`endif

// ### hw/ttmc_pkg.sv
// types of the tape transport mode controller
// used by the controller top module and the bench
package ttmc_pkg;
  typedef enum logic [2:0] {
    TTMC_STOP = 3'b000,
    TTMC_PLAY = 3'b001,
    TTMC_REC = 3'b010,
    TTMC_FF = 3'b011,
    TTMC_REW = 3'b100,
    TTMC_SPOOL_FF = 3'b101,
    TTMC_SPOOL_REW = 3'b110
  } ttmc_mode_type;
endpackage

// ### hw/ttmc_ctrl.sv
// tape transport mode controller with an APB register slave
// assumes buttons are synchronous to pclk and active high
//
// Summary of operation
// - at reset light repro, stop and edit lamps; safe lamps follow unready channels; zero timer.
// - speed selector gives four speeds; chosen speed goes to the servos.
// - unset speed lights inhibit lamp, refuses play and record, mutes audio.
// - during speed inhibit, command the accessory to monitor input.
// - after power-up the inhibit lamp lights for about 2.5 seconds.
// - stop held with arm tension engages reel servos and enters thread.
// - entering thread mode turns the edit lamp off.
// - edit with tape stopped in thread releases servos, leaves thread.
// - stopped in thread, capstan knob moves tape under reel servo control.
// - stop lamp lit while stop is the active mode.
// - play alone selects play; play with record selects record.
// - play during fast forward or rewind goes straight to play.
// - play with fast forward or rewind selects spool that direction.
// - play lamp only in play, record or spool with capstan lock.
// - record starts only on channels in the ready state.
// - rewind lamp on in rewind or rewind spool.
// - fast forward lamp on in fast forward or forward spool.
`timescale 1ns/100ps
`include "ttmc_map.svh"
module ttmc_ctrl
  import ttmc_pkg::*;
#(
  parameter int LOCK_CYC = `TTMC_LOCK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic btn_play,
  input wire logic btn_rec,
  input wire logic btn_stop,
  input wire logic btn_ff,
  input wire logic btn_rew,
  input wire logic btn_edit,
  input wire logic [1:0] speed_sel,
  input wire logic arm_tension,
  input wire logic capstan_lock,
  input wire logic io_attached,
  input wire logic [3:0] ch_ready,
  output logic [1:0] servo_speed,
  output logic [2:0] transport_mode,
  output logic reel_servo_en,
  output logic thread_mode,
  output logic [3:0] ch_record,
  output logic [3:0] safe_lamp,
  output logic [3:0] repro_lamp,
  output logic stop_lamp,
  output logic edit_lamp,
  output logic play_lamp,
  output logic ff_lamp,
  output logic rew_lamp,
  output logic speed_inhibit_lamp,
  output logic audio_mute,
  output logic io_monitor_input,
  output logic timer_clear,
  output logic irq
);

  localparam int DEB_CYC = `TTMC_DEB_CYC;
  localparam int PAIR_CYC = `TTMC_PAIR_CYC;

  // debounce: a level must hold DEB_CYC cycles to be accepted
  logic [5:0] btn_raw;
  wire [5:0] btn_deb_r;
  logic [5:0] btn_prev_r;
  logic [5:0] btn_rise;
  assign btn_raw = {btn_edit, btn_rew, btn_ff, btn_stop, btn_rec, btn_play};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_deb
      logic [11:0] cnt_r;
      logic deb_r;
      assign btn_deb_r[gi] = deb_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= 12'h000;
          deb_r <= 1'b0;
        end else if (btn_raw[gi] == deb_r) begin
          cnt_r <= 12'h000;
        end else if (cnt_r == 12'(DEB_CYC - 1)) begin
          cnt_r <= 12'h000;
          deb_r <= btn_raw[gi];
        end else begin
          cnt_r <= cnt_r + 12'h001;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) btn_prev_r <= 6'h00;
    else btn_prev_r <= btn_deb_r;
  end
  assign btn_rise = btn_deb_r & ~btn_prev_r;

  // pairing window: presses seen since first press, decided at its end
  logic [5:0] pend_r;
  logic [13:0] pair_cnt_r;
  logic pair_busy_r;
  logic pair_done;
  logic [5:0] req;
  assign pair_done = pair_busy_r && pair_cnt_r == 14'(PAIR_CYC - 1);
  assign req = pair_done ? (pend_r | btn_rise) : 6'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 6'h00;
      pair_cnt_r <= 14'h0000;
      pair_busy_r <= 1'b0;
    end else if (pair_done) begin
      pend_r <= 6'h00;
      pair_cnt_r <= 14'h0000;
      pair_busy_r <= 1'b0;
    end else if (pair_busy_r || btn_rise != 6'h00) begin
      pend_r <= pend_r | btn_rise;
      pair_busy_r <= 1'b1;
      pair_cnt_r <= pair_cnt_r + 14'h0001;
    end
  end

  wire rq_play = req[0];
  wire rq_rec = req[1];
  wire rq_stop = req[2];
  wire rq_ff = req[3];
  wire rq_rew = req[4];
  wire rq_edit = req[5];

  // registers
  logic master_en_r;
  logic [3:0] setup_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic [31:0] lock_cnt_r;
  logic power_lock;
  logic speed_bad;
  logic inhibit;

  // power-up speed_inhibit_lamp timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_cnt_r <= 32'h00000000;
    else if (power_lock) lock_cnt_r <= lock_cnt_r + 32'h00000001;
  end
  assign power_lock = lock_cnt_r < 32'(LOCK_CYC);
  assign speed_bad = !setup_r[speed_sel];
  assign inhibit = speed_bad || power_lock;
  assign speed_inhibit_lamp = inhibit;
  assign audio_mute = speed_bad;
  assign io_monitor_input = speed_bad && io_attached;
  assign servo_speed = speed_sel;

  // transport mode
  ttmc_mode_type mode_r, mode_nxt;
  logic thread_r, thread_nxt;
  logic edit_lamp_r, edit_lamp_nxt;
  logic [3:0] rec_r;
  logic [3:0] rec_nxt;
  wire spool_req = rq_play && (rq_ff || rq_rew);
  wire spool_dir_ff = rq_ff;
  wire in_shuttle = mode_r == TTMC_FF || mode_r == TTMC_REW;

  always_comb begin
    mode_nxt = mode_r;
    thread_nxt = thread_r;
    edit_lamp_nxt = edit_lamp_r;
    rec_nxt = rec_r;
    if (btn_deb_r[2] && arm_tension && !thread_r) begin
      thread_nxt = 1'b1;
      edit_lamp_nxt = 1'b0;
    end
    if (rq_stop) begin
      mode_nxt = TTMC_STOP;
      rec_nxt = 4'h0;
    end else if (spool_req) begin
      mode_nxt = spool_dir_ff ? TTMC_SPOOL_FF : TTMC_SPOOL_REW;
    end else if (rq_play && rq_rec && !inhibit) begin
      mode_nxt = TTMC_REC;
      rec_nxt = ch_ready & {4{master_en_r}};
    end else if (rq_play && !inhibit) begin
      mode_nxt = TTMC_PLAY;
    end else if (rq_ff) begin
      mode_nxt = TTMC_FF;
    end else if (rq_rew) begin
      mode_nxt = TTMC_REW;
    end else if (rq_edit && mode_r == TTMC_STOP && thread_r &&
      !(btn_deb_r[2] && arm_tension)) begin
      thread_nxt = 1'b0;
    end
    if (in_shuttle && rq_play && !spool_req && !rq_stop && inhibit) begin
      mode_nxt = mode_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= TTMC_STOP;
      thread_r <= 1'b0;
      edit_lamp_r <= 1'b1;
      rec_r <= 4'h0;
    end else begin
      mode_r <= mode_nxt;
      thread_r <= thread_nxt;
      edit_lamp_r <= edit_lamp_nxt;
      rec_r <= rec_nxt;
    end
  end

  assign transport_mode = mode_r;
  assign thread_mode = thread_r;
  // servos hold tape in thread so knob motion moves reel to reel
  assign reel_servo_en = thread_r;
  assign ch_record = rec_r;
  assign edit_lamp = edit_lamp_r;
  assign stop_lamp = mode_r == TTMC_STOP;
  assign play_lamp = capstan_lock && (mode_r == TTMC_PLAY ||
    mode_r == TTMC_REC || mode_r == TTMC_SPOOL_FF ||
    mode_r == TTMC_SPOOL_REW);
  assign ff_lamp = mode_r == TTMC_FF || mode_r == TTMC_SPOOL_FF;
  assign rew_lamp = mode_r == TTMC_REW || mode_r == TTMC_SPOOL_REW;
  assign safe_lamp = ~ch_ready;
  assign repro_lamp = {4{1'b1}};

  // timer clear held during reset, dropped on first clock after release
  logic tclr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tclr_r <= 1'b1;
    else tclr_r <= 1'b0;
  end
  assign timer_clear = tclr_r;

  // interrupt events: mode change, thread entry, refused play, lock end
  logic [3:0] ev;
  logic plock_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) plock_prev_r <= 1'b1;
    else plock_prev_r <= power_lock;
  end
  assign ev[0] = mode_nxt != mode_r;
  assign ev[1] = thread_nxt && !thread_r;
  assign ev[2] = rq_play && inhibit && !spool_req;
  assign ev[3] = plock_prev_r && !power_lock;

  // apb slave, zero wait states
  logic acc, wr;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  wire hit_ctrl = paddr == `TTMC_ADDR_CTRL;
  wire hit_stat = paddr == `TTMC_ADDR_STAT;
  wire hit_istat = paddr == `TTMC_ADDR_IRQ_STAT;
  wire hit_imask = paddr == `TTMC_ADDR_IRQ_MASK;
  wire hit_setup = paddr == `TTMC_ADDR_SETUP;
  wire hit_any = hit_ctrl | hit_stat | hit_istat | hit_imask | hit_setup;
  assign pslverr = acc && !hit_any;
  wire [31:0] stat_word = {16'h0000, rec_r, inhibit, thread_r,
    speed_sel, 5'h00, mode_r};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, master_en_r} :
    hit_stat ? stat_word :
    hit_istat ? {28'h0, irq_stat_r} :
    hit_imask ? {28'h0, irq_mask_r} :
    hit_setup ? {28'h0, setup_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_en_r <= 1'b1;
      setup_r <= `TTMC_SETUP_RST;
      irq_mask_r <= 4'h0;
      prdata <= 32'h00000000;
    end else begin
      if (wr && hit_ctrl) master_en_r <= pwdata[`TTMC_CTRL_MASTER_BIT];
      if (wr && hit_setup) setup_r <= pwdata[3:0];
      if (wr && hit_imask) irq_mask_r <= pwdata[3:0];
      if (psel && !penable && !pwrite) prdata <= rd_mux;
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_stat_r <= 4'h0;
    else irq_stat_r <= ev |
      (irq_stat_r & ~((wr && hit_istat) ? pwdata[3:0] : 4'h0));
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // checks
  sequence s_stop_req;
    rq_stop;
  endsequence
  sequence s_in_stop;
    ##1 mode_r == TTMC_STOP ##0 stop_lamp;
  endsequence
  stop_lamp_a: assert property (
    @(posedge pclk) disable iff (!presetn) s_stop_req |-> s_in_stop)
    else $error("stop lamp missing");
  inhibit_refuse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rq_play && inhibit && mode_r == TTMC_STOP && !spool_req)
    |=> mode_r == TTMC_STOP) else $error("play taken in inhibit");
  rec_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(|rec_r) |-> (rec_r & ~$past(ch_ready)) == 4'h0)
    else $error("record on unready channel");
  thread_edit_a: assert property (
    @(posedge pclk) disable iff (!presetn) $rose(thread_r) |-> !edit_lamp_r)
    else $error("edit lamp stayed");
  thread_enter_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (btn_deb_r[2] && arm_tension) |=> thread_r)
    else $error("thread not entered");
  untread_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rq_edit && mode_r == TTMC_STOP && thread_r && req[4:0] == 5'h00
    && !(btn_deb_r[2] && arm_tension)) |=> !reel_servo_en)
    else $error("servos kept");
  play_lamp_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    play_lamp |-> capstan_lock && mode_r != TTMC_STOP)
    else $error("play lamp wrong");
  spool_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (spool_req && !rq_stop) |=> ff_lamp || rew_lamp)
    else $error("spool lamp missing");
  lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    power_lock |-> speed_inhibit_lamp) else $error("lock lamp off");
  monitor_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (speed_bad && io_attached) |-> io_monitor_input && audio_mute)
    else $error("no input monitor");
  rec_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rq_play && rq_rec && !rq_stop && !spool_req && !inhibit)
    |=> mode_r == TTMC_REC) else $error("record not selected");
  shuttle_play_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (in_shuttle && rq_play && !rq_rec && !rq_stop && !spool_req
    && !inhibit) |=> mode_r == TTMC_PLAY) else $error("play not taken");
  ff_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rq_ff && !rq_play && !rq_stop) |=> ff_lamp && !rew_lamp)
    else $error("ff lamp missing");
  rew_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rq_rew && !rq_play && !rq_ff && !rq_stop) |=> rew_lamp && !ff_lamp)
    else $error("rew lamp missing");
  lock_count_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    power_lock |=> lock_cnt_r == $past(lock_cnt_r) + 32'h00000001)
    else $error("lock counter stalled");
endmodule // ttmc_ctrl

// ### bench/ttmc_servo_model.sv
// reel and capstan servo partner for the transport controller
// assumes the controller's pclk and presetn
`timescale 1ns/100ps
module ttmc_servo_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] transport_mode,
  input wire logic reel_servo_en,
  input wire logic tug,
  output logic capstan_lock,
  output logic arm_tension
);
  logic [4:0] lock_cnt_r;
  wire logic run;
  assign run = transport_mode inside {3'h1, 3'h2, 3'h5, 3'h6};
  // engaged reel servos keep the arms tensioned
  assign arm_tension = reel_servo_en | tug;
  assign capstan_lock = lock_cnt_r == 5'h1F;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_cnt_r <= 5'h00;
    else if (!run) lock_cnt_r <= 5'h00;
    else if (!capstan_lock) lock_cnt_r <= lock_cnt_r + 5'h01;
  end
endmodule // ttmc_servo_model

// ### bench/test_tape_transport_mode_control.sv
// self-checking bench for the transport mode controller
// assumes the servo partner model and a 200 MHz pclk
`timescale 1ns/100ps
`include "ttmc_map.svh"
module test_tape_transport_mode_control;
  import ttmc_pkg::*;
  localparam int LOCK = 15000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, io_attached = 1'b0, tug = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] btn = 6'h00;
  logic [1:0] speed_sel = 2'h1, servo_speed;
  logic [3:0] ch_ready = 4'hA, ch_record, safe_lamp, repro_lamp;
  logic [2:0] transport_mode;
  logic pready, pslverr, capstan_lock, arm_tension, reel_servo_en;
  logic thread_mode, stop_lamp, edit_lamp, play_lamp, ff_lamp, rew_lamp;
  logic speed_inhibit_lamp, audio_mute, io_monitor_input, timer_clear, irq;
  int bad_count = 0, checked = 0;
  always #2.5 pclk = ~pclk;
  ttmc_ctrl #(.LOCK_CYC(LOCK)) ttmc_ctrl_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .btn_play(btn[0]), .btn_rec(btn[1]), .btn_stop(btn[2]),
    .btn_ff(btn[3]), .btn_rew(btn[4]), .btn_edit(btn[5]), .speed_sel,
    .arm_tension, .capstan_lock, .io_attached, .ch_ready, .servo_speed,
    .transport_mode, .reel_servo_en, .thread_mode, .ch_record, .safe_lamp,
    .repro_lamp, .stop_lamp, .edit_lamp, .play_lamp, .ff_lamp, .rew_lamp,
    .speed_inhibit_lamp, .audio_mute, .io_monitor_input, .timer_clear,
    .irq);
  ttmc_servo_model ttmc_servo_model_i (.pclk, .presetn, .transport_mode,
    .reel_servo_en, .tug, .capstan_lock, .arm_tension);
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // press, hold past debounce, release, wait out the pairing window
  task automatic press(input logic [5:0] b);
    @(posedge pclk);
    btn <= b;
    repeat (2100) @(posedge pclk);
    btn <= 6'h00;
    tug <= 1'b0;
    repeat (10000) @(posedge pclk);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    #1;
    chk({stop_lamp, edit_lamp, timer_clear, speed_inhibit_lamp, safe_lamp,
      repro_lamp}, {4'hF, 4'h5, 4'hF});
    chk(transport_mode, TTMC_STOP);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `TTMC_ADDR_IRQ_MASK, 32'h4, e);
    chk({timer_clear, pready, e}, 3'b010);
    apb(1'b0, `TTMC_ADDR_CTRL, 32'h0, e);
    chk(rd, 32'h1);
    apb(1'b0, `TTMC_ADDR_SETUP, 32'h0, e);
    chk(rd, 32'h6);
    apb(1'b0, 12'h020, 32'h0, e);
    chk({e, rd[30:0]}, 32'h80000000);
    chk(servo_speed, 2'h1);
    press(6'h01);
    chk({transport_mode, speed_inhibit_lamp, irq}, {TTMC_STOP, 2'b11});
    apb(1'b0, `TTMC_ADDR_IRQ_STAT, 32'h0, e);
    chk(rd[2], 1'b1);
    apb(1'b1, `TTMC_ADDR_IRQ_STAT, 32'h4, e);
    chk(irq, 1'b0);
    repeat (3000) @(posedge pclk);
    #1;
    chk(speed_inhibit_lamp, 1'b0);
    press(6'h03);
    chk({transport_mode, ch_record}, {TTMC_REC, 4'hA});
    apb(1'b0, `TTMC_ADDR_STAT, 32'h0, e);
    chk(rd, 32'h0000A102);
    @(posedge pclk);
    tug <= 1'b1;
    press(6'h04);
    chk({transport_mode, stop_lamp, ch_record}, {TTMC_STOP, 5'h10});
    chk({thread_mode, reel_servo_en, edit_lamp}, 3'b110);
    press(6'h20);
    chk({thread_mode, reel_servo_en, edit_lamp}, 3'b000);
    press(6'h08);
    chk({transport_mode, ff_lamp, rew_lamp, play_lamp},
      {TTMC_FF, 3'b100});
    press(6'h01);
    chk({transport_mode, play_lamp, stop_lamp}, {TTMC_PLAY, 2'b10});
    press(6'h11);
    chk({transport_mode, rew_lamp, ff_lamp, play_lamp},
      {TTMC_SPOOL_REW, 3'b101});
    @(posedge pclk);
    speed_sel <= 2'h0;
    io_attached <= 1'b1;
    @(posedge pclk);
    #1;
    chk({servo_speed, speed_inhibit_lamp, audio_mute, io_monitor_input},
      5'b00111);
    summarize();
  end
endmodule // test_tape_transport_mode_control
